/* File: inc/reseq_pkg.sv */
/*
 package for the reset and exception-entry sequencer: constants,
 state enum and the carrier structs. assumes an 8-bit core with a
 16-bit address space and a word-wide reset vector.
*/
// Behaviour
// - reset outranks every pending interrupt request
// - reset handling starts right after release
// - interrupt entry only at instruction or exception end
// - chip clear low halts everything after the two-stage pin synchroniser
// - initialise state, set interrupt mask flag
// - load program counter from vector, then fetch
// - mask interrupts until first instruction completes
package reseq_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam logic [ADDR_W-1:0] RESET_VEC_HI_ADDR = 16'h0000;
   localparam logic [ADDR_W-1:0] RESET_VEC_LO_ADDR = 16'h0001;
   localparam logic [7:0] FLAGS_RESET_VAL = 8'h80;
   localparam int unsigned FLAG_IMASK_BIT = 7;
   localparam int unsigned MIN_RESET_CYCLES = 10;
   localparam int unsigned SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      RESEQ_HOLD,
      RESEQ_INIT,
      RESEQ_VEC_HI,
      RESEQ_VEC_LO,
      RESEQ_FIRST,
      RESEQ_RUN,
      RESEQ_IRQ
   } reseq_state_e;

   // memory read request toward the core bus
   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
   } reseq_mem_s;

   // status seen by the core
   typedef struct packed {
      logic in_reset;
      logic periph_clear;
      logic fetch_go;
      logic irq_take;
   } reseq_ctl_s;
endpackage

/* File: hdl/reseq_top.sv */
/*
 reset and exception-entry sequencer. holds the core in reset while
 chip_clear_input_n is low, then fetches the reset vector, sets the
 interrupt mask flag and releases the core. interrupt entry is offered
 only at instruction boundaries. assumes the bus answers a read in the
 cycle after rd with valid data and the core pulses instr_done.
*/
`timescale 1ns/1ps
module reseq_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic chip_clear_input_n,
   input wire logic [7:0] mem_rdata,
   input wire logic instr_done,
   input wire logic irq_pending,
   input wire logic flags_imask,
   output reseq_pkg::reseq_mem_s mem_req,
   output reseq_pkg::reseq_ctl_s ctl,
   output logic [reseq_pkg::ADDR_W-1:0] program_counter,
   output logic set_imask
);
   import reseq_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // elaboration checks on the constants this logic relies on
   if (SYNC_STAGES < 2) begin : g_chk_sync
      $error("reseq_top: clear pin synchroniser needs two stages");
   end
   if (FLAG_IMASK_BIT > 7) begin : g_chk_flag
      $error("reseq_top: mask flag bit lies outside the flags byte");
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser; first stage feeds only the second
   logic [SYNC_STAGES-1:0] clr_sync_q;
   logic clr_low;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clr_sync_q <= '0;
      end else begin
         clr_sync_q <= {clr_sync_q[SYNC_STAGES-2:0], chip_clear_input_n};
      end
   end

   assign clr_low = !clr_sync_q[SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////
   // sequencer
   reseq_state_e state_q;
   logic [7:0] vec_hi_q;

   // a low pin wins from every state, so reset always beats interrupts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RESEQ_HOLD;
      end else if (clr_low) begin
         state_q <= RESEQ_HOLD;
      end else begin
         unique case (state_q)
            RESEQ_HOLD: state_q <= RESEQ_INIT;
            RESEQ_INIT: state_q <= RESEQ_VEC_HI;
            RESEQ_VEC_HI: state_q <= RESEQ_VEC_LO;
            RESEQ_VEC_LO: state_q <= RESEQ_FIRST;
            // no interrupt until the first instruction is done
            RESEQ_FIRST: if (instr_done) begin
               state_q <= RESEQ_RUN;
            end
            RESEQ_RUN: if (instr_done && irq_pending && !flags_imask) begin
               state_q <= RESEQ_IRQ;
            end
            // entry itself is handled by the core; one cycle handoff
            RESEQ_IRQ: state_q <= RESEQ_RUN;
            // the unused code falls back into reset
            default: state_q <= RESEQ_HOLD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // vector capture; data arrives the cycle after each read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vec_hi_q <= '0;
      end else if (state_q == RESEQ_VEC_LO) begin
         vec_hi_q <= mem_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output registers and their next values
   logic vec_rd_d;
   logic vec_rd_q;
   logic [ADDR_W-1:0] vec_addr_d;
   logic [ADDR_W-1:0] vec_addr_q;
   logic in_reset_d;
   logic in_reset_q;
   logic periph_clear_d;
   logic periph_clear_q;
   logic fetch_go_d;
   logic fetch_go_q;
   logic irq_take_d;
   logic irq_take_q;
   logic set_imask_d;
   logic set_imask_q;
   logic pc_load_d;
   logic [ADDR_W-1:0] pc_q;

   // a low pin forces every output except program_counter (cleared every cycle in RESEQ_HOLD and RESEQ_INIT) to its reset value, which also
   // keeps an interrupt from slipping in while reset is pending
   always_comb begin
      vec_rd_d = 1'b0;
      vec_addr_d = RESET_VEC_HI_ADDR;
      in_reset_d = 1'b1;
      // peripherals cleared through the whole reset phase
      periph_clear_d = 1'b1;
      set_imask_d = FLAGS_RESET_VAL[FLAG_IMASK_BIT];
      fetch_go_d = 1'b0;
      irq_take_d = 1'b0;
      pc_load_d = 1'b0;
      if (!clr_low) begin
         unique case (state_q)
            RESEQ_HOLD: begin
               vec_rd_d = 1'b0;
            end
            RESEQ_INIT: begin
               vec_rd_d = 1'b1;
            end
            RESEQ_VEC_HI: begin
               vec_rd_d = 1'b1;
               vec_addr_d = RESET_VEC_LO_ADDR;
            end
            RESEQ_VEC_LO: begin
               vec_rd_d = 1'b0;
            end
            // low vector byte stands on the bus in the first cycle here
            RESEQ_FIRST: begin
               in_reset_d = 1'b0;
               periph_clear_d = 1'b0;
               set_imask_d = 1'b0;
               fetch_go_d = 1'b1;
               pc_load_d = !fetch_go_q;
            end
            RESEQ_RUN: begin
               in_reset_d = 1'b0;
               periph_clear_d = 1'b0;
               set_imask_d = 1'b0;
               fetch_go_d = 1'b1;
               irq_take_d = instr_done && irq_pending
                            && !flags_imask;
            end
            RESEQ_IRQ: begin
               in_reset_d = 1'b0;
               periph_clear_d = 1'b0;
               set_imask_d = 1'b0;
               fetch_go_d = 1'b1;
            end
            default: begin
               vec_rd_d = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // one register block per output concern
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vec_rd_q <= 1'b0;
         vec_addr_q <= RESET_VEC_HI_ADDR;
      end else begin
         vec_rd_q <= vec_rd_d;
         vec_addr_q <= vec_addr_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_reset_q <= 1'b1;
      end else begin
         in_reset_q <= in_reset_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         periph_clear_q <= 1'b1;
      end else begin
         periph_clear_q <= periph_clear_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_go_q <= 1'b0;
      end else begin
         fetch_go_q <= fetch_go_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_q <= 1'b0;
      end else begin
         irq_take_q <= irq_take_d;
      end
   end

   // mask held until the vector is in; the first instruction is then
   // protected by the sequencer state, not by the flag
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         set_imask_q <= 1'b1;
      end else begin
         set_imask_q <= set_imask_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= RESET_VEC_HI_ADDR;
      end else if (state_q == RESEQ_HOLD || state_q == RESEQ_INIT) begin
         pc_q <= RESET_VEC_HI_ADDR;
      end else if (pc_load_d) begin
         pc_q <= {vec_hi_q, mem_rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ports driven straight from the flops
   assign mem_req.rd = vec_rd_q;
   assign mem_req.addr = vec_addr_q;
   assign ctl.in_reset = in_reset_q;
   assign ctl.periph_clear = periph_clear_q;
   assign ctl.fetch_go = fetch_go_q;
   assign ctl.irq_take = irq_take_q;
   assign program_counter = pc_q;
   assign set_imask = set_imask_q;
endmodule

/* File: verification/reseq_asserts.sv */
/* port checks for reseq_top; one clock, bound after the module */
`timescale 1ns/1ps
module reseq_asserts
   import reseq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic chip_clear_input_n,
   input wire logic [7:0] mem_rdata,
   input wire logic instr_done,
   input wire logic irq_pending,
   input wire logic flags_imask,
   input reseq_pkg::reseq_mem_s mem_req,
   input reseq_pkg::reseq_ctl_s ctl,
   input wire logic [reseq_pkg::ADDR_W-1:0] program_counter,
   input wire logic set_imask
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_vec;
      mem_req.rd && mem_req.addr == RESET_VEC_HI_ADDR
      ##1 mem_req.rd && mem_req.addr == RESET_VEC_LO_ADDR;
   endsequence
   property p_vec;
      s_vec |-> ##2 ctl.fetch_go &&
      program_counter == {$past(mem_rdata, 2), $past(mem_rdata)};
   endproperty
   a_vec: assert property (p_vec) else $error("vec");
   property p_hold; !chip_clear_input_n |-> ##4 ctl.in_reset; endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_imask; ctl.in_reset |-> set_imask && ctl.periph_clear;
   endproperty
   a_imask: assert property (p_imask) else $error("imask");
   property p_prio; ctl.in_reset |-> !ctl.irq_take; endproperty
   a_prio: assert property (p_prio) else $error("prio");
   property p_irq; ctl.irq_take |->
      $past(instr_done) && $past(irq_pending) && !$past(flags_imask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_once; ctl.irq_take |=> !ctl.irq_take; endproperty
   a_once: assert property (p_once) else $error("once");
   property p_start; $rose(chip_clear_input_n) |-> ##[2:6] s_vec;
   endproperty
   a_start: assert property (p_start) else $error("start");
   property p_first; $rose(ctl.fetch_go) |-> !ctl.irq_take [*2]; endproperty
   a_first: assert property (p_first) else $error("first");
endmodule
bind reseq_top reseq_asserts u_chk (.*);

/* File: verification/reseq_src.sv */
/* clear pin source: low from power-up, low 10+ clocks on request */
`timescale 1ns/1ps
module reseq_src
   import reseq_pkg::*;
(
   input wire logic mclk,
   input wire logic clr_req,
   output logic chip_clear_input_n
);
   int cnt = 8;
   logic pin_q = 1'b0; // low until the clock settles
   assign chip_clear_input_n = pin_q;
   always @(posedge mclk) begin
      cnt <= clr_req ? MIN_RESET_CYCLES : (cnt != 0 ? cnt - 1 : 0);
      pin_q <= cnt == 0 && !clr_req;
   end
endmodule

/* File: verification/tb_top.sv */
/* bench for reseq_top; memory answers vector reads a cycle late */
`timescale 1ns/1ps
module tb_top;
   import reseq_pkg::*;
   logic mclk = 0, rst_n = 0, clr_req = 0, chip_clear_input_n;
   logic instr_done = 0, irq_pending = 1, flags_imask = 0, set_imask;
   logic [7:0] mem_rdata = 8'h00;
   logic [ADDR_W-1:0] pc;
   reseq_mem_s mem_req;
   reseq_ctl_s ctl;
   int n_errors = 0, num_checks = 0;
   logic [2:0] core_st;
   assign core_st = {ctl.in_reset, ctl.fetch_go, ctl.irq_take};
   always #25 mclk = ~mclk;
   // idle bus shows inverted data so a late capture cannot pass
   always @(posedge mclk)
      mem_rdata <= mem_req.rd ? (mem_req.addr[0] ? 8'h3c : 8'ha5) : ~mem_rdata;
   reseq_src u_src (.mclk, .clr_req, .chip_clear_input_n);
   reseq_top dut (.mclk, .rst_n, .chip_clear_input_n, .mem_rdata,
      .instr_done, .irq_pending, .flags_imask, .mem_req, .ctl,
      .program_counter(pc), .set_imask);
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_fetch;
      for (int n = 0; ctl.fetch_go !== 1'b1; n++) begin
         if (n == 60) begin
            n_errors++;
            close_out();
         end
         @(posedge mclk);
         #1;
      end
      check("pc", pc, 16'ha53c);
   endtask
   task automatic pulse_done(logic exp);
      @(posedge mclk) instr_done <= 1'b1;
      @(posedge mclk) instr_done <= 1'b0;
      #1 check("irq_take", ctl.irq_take, exp);
   endtask
   task automatic t_boot;
      @(posedge mclk);
      #1 check("held", core_st, 3'b100);
      check("clear_mask", {ctl.periph_clear, set_imask}, 2'b11);
      wait_fetch();
   endtask
   task automatic t_irq;
      pulse_done(1'b0);
      pulse_done(1'b1);
      @(posedge mclk) flags_imask <= 1'b1;
      pulse_done(1'b0);
      @(posedge mclk) begin
         flags_imask <= 1'b0;
         irq_pending <= 1'b0;
      end
      pulse_done(1'b0);
      @(posedge mclk) irq_pending <= 1'b1;
   endtask
   task automatic t_clear;
      @(posedge mclk) clr_req <= 1'b1;
      // instructions keep ending with an interrupt pending during the clear
      @(posedge mclk) begin
         clr_req <= 1'b0;
         instr_done <= 1'b1;
      end
      repeat (3) @(posedge mclk);
      #1 check("clear", core_st, 3'b100);
      @(posedge mclk) instr_done <= 1'b0;
      #1 check("cleared", core_st, 3'b100);
      wait_fetch();
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      t_boot();
      t_irq();
      t_clear();
      close_out();
   end
endmodule
